/* File: src/brtg_guard.sv */
// brake resistor thermal guard: model, protection and register slave
// Functional notes
// - keep estimate, zero ambient, full is maximum
// - warn above 75 % while switch conducts
// - modes 0 and 1 trip at 100 %
// - modes 2 and 3 force switch off instead
// - inhibit held until estimate below 95 %
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
module brtg_guard
  import brtg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic brake_request,
  input wire logic [15:0] dc_bus_voltage,
  output logic brake_gate_en,
  output logic brake_heat_warning,
  output logic resistor_overtemp_trip,
  output logic irq
);
  if (TICK_CYC < 2 * DIV_W + 8 || TICK_CYC > 32'h00FF_FFFF)
    $error("brtg_guard: TICK_CYC out of range");

  brtg_div_if #(.W(DIV_W)) div_bus ();

  brtg_divider #(.W(DIV_W)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .div(div_bus.divider)
  );

  // configuration and status registers
  logic enable_r, enable_nxt;
  logic [1:0] overload_protection_mode_r, overload_protection_mode_nxt;
  logic [15:0] resistor_rated_power_r, resistor_rated_power_nxt;
  logic [15:0] resistor_thermal_time_constant_r;
  logic [15:0] resistor_thermal_time_constant_nxt;
  logic [15:0] resistor_resistance_value_r, resistor_resistance_value_nxt;
  logic [ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_take, cfg_ok, run;
  logic [ST_W-1:0] events;

  brtg_state_e state_r, state_nxt;
  logic [23:0] tick_r, tick_nxt;
  logic [EST_W-1:0] resistor_temperature_estimate_r, est_nxt;
  logic [DIV_W-1:0] num_r, num_nxt, den_r, den_nxt;
  logic start_r, start_nxt, heating_r, heating_nxt;
  logic [DIV_W-1:0] est_wide, sum;

  logic trip_r, trip_nxt, inhibit_r, inhibit_nxt, warn_q;

  assign cfg_ok = (resistor_rated_power_r != 16'h0000) &&
                  (resistor_thermal_time_constant_r != 16'h0000) &&
                  (resistor_resistance_value_r != 16'h0000);
  assign run = enable_r && cfg_ok;
  assign wr_take = avs_write && ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  // register slave: answer one cycle after the request appears
  always_comb
  begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    enable_nxt = enable_r;
    overload_protection_mode_nxt = overload_protection_mode_r;
    resistor_rated_power_nxt = resistor_rated_power_r;
    resistor_thermal_time_constant_nxt = resistor_thermal_time_constant_r;
    resistor_resistance_value_nxt = resistor_resistance_value_r;
    mask_nxt = mask_r;
    if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        OFF_CTRL: rdata_nxt = {26'h0, overload_protection_mode_r,
                               3'h0, enable_r};
        OFF_POWER: rdata_nxt = {16'h0, resistor_rated_power_r};
        OFF_TAU: rdata_nxt = {16'h0, resistor_thermal_time_constant_r};
        OFF_RES: rdata_nxt = {16'h0, resistor_resistance_value_r};
        OFF_EST: rdata_nxt = {7'h0, resistor_temperature_estimate_r};
        OFF_STATUS: rdata_nxt = {28'h0, status_r};
        OFF_MASK: rdata_nxt = {28'h0, mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_take)
    begin
      unique case (avs_address)
        OFF_CTRL:
        begin
          enable_nxt = avs_writedata[CTRL_EN_BIT];
          overload_protection_mode_nxt =
            avs_writedata[CTRL_MODE_LSB +: 2];
        end
        OFF_POWER: resistor_rated_power_nxt = avs_writedata[15:0];
        OFF_TAU: resistor_thermal_time_constant_nxt = avs_writedata[15:0];
        OFF_RES: resistor_resistance_value_nxt = avs_writedata[15:0];
        OFF_MASK: mask_nxt = avs_writedata[ST_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clearing write
    status_nxt = status_r | events;
    if (wr_take && avs_address == OFF_STATUS)
      status_nxt = (status_r & ~avs_writedata[ST_W-1:0]) | events;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      enable_r <= 1'b0;
      overload_protection_mode_r <= MODE_RESET;
      resistor_rated_power_r <= 16'h0000;
      resistor_thermal_time_constant_r <= 16'h0000;
      resistor_resistance_value_r <= 16'h0000;
      status_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      enable_r <= enable_nxt;
      overload_protection_mode_r <= overload_protection_mode_nxt;
      resistor_rated_power_r <= resistor_rated_power_nxt;
      resistor_thermal_time_constant_r <=
        resistor_thermal_time_constant_nxt;
      resistor_resistance_value_r <= resistor_resistance_value_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end

  // thermal model: one step per tick
  assign est_wide = {{(DIV_W-EST_W){1'b0}}, resistor_temperature_estimate_r};
  assign sum = est_wide + div_bus.quot;
  assign div_bus.start = start_r;
  assign div_bus.num = num_r;
  assign div_bus.den = den_r;

  always_comb
  begin
    state_nxt = state_r;
    tick_nxt = tick_r;
    est_nxt = resistor_temperature_estimate_r;
    num_nxt = num_r;
    den_nxt = den_r;
    start_nxt = 1'b0;
    heating_nxt = heating_r;
    if (!run)
    begin
      state_nxt = BRTG_IDLE;
      tick_nxt = 24'h000000;
      est_nxt = '0;
    end
    else
    begin
      unique case (state_r)
        BRTG_IDLE:
        begin
          tick_nxt = tick_r + 24'h000001;
          if (tick_r == 24'(TICK_CYC - 1))
          begin
            tick_nxt = 24'h000000;
            if (brake_gate_en)
            begin
              // power in W: V^2 * 10 / (R in 0.1 ohm)
              num_nxt = 64'(dc_bus_voltage) * 64'(dc_bus_voltage)
                        * RES_SCALE;
              den_nxt = 64'(resistor_resistance_value_r);
              start_nxt = 1'b1;
              state_nxt = BRTG_POW;
            end
            else
            begin
              state_nxt = BRTG_TAU;
              start_nxt = 1'b1;
              num_nxt = est_wide;
              den_nxt = 64'(resistor_thermal_time_constant_r);
              heating_nxt = 1'b0;
            end
          end
        end
        BRTG_POW:
          if (div_bus.done)
          begin
            // dissipated power relative to rating, full scale 2^24
            num_nxt = {div_bus.quot[DIV_W-EST_FRAC-1:0],
                       {EST_FRAC{1'b0}}};
            den_nxt = 64'(resistor_rated_power_r);
            start_nxt = 1'b1;
            state_nxt = BRTG_FRAC;
          end
        BRTG_FRAC:
          if (div_bus.done)
          begin
            heating_nxt = div_bus.quot > est_wide;
            num_nxt = (div_bus.quot > est_wide) ?
                      div_bus.quot - est_wide : est_wide - div_bus.quot;
            den_nxt = 64'(resistor_thermal_time_constant_r);
            start_nxt = 1'b1;
            state_nxt = BRTG_TAU;
          end
        BRTG_TAU:
          if (div_bus.done)
            state_nxt = BRTG_APPLY;
        BRTG_APPLY:
        begin
          // first order step toward the power ratio, 1 ms over tau
          if (heating_r)
            est_nxt = (sum >= 64'(EST_FULL)) ? EST_FULL
                      : sum[EST_W-1:0];
          else
            est_nxt = resistor_temperature_estimate_r
                      - div_bus.quot[EST_W-1:0];
          state_nxt = BRTG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= BRTG_IDLE;
      tick_r <= 24'h000000;
      resistor_temperature_estimate_r <= '0;
      num_r <= '0;
      den_r <= '0;
      start_r <= 1'b0;
      heating_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      resistor_temperature_estimate_r <= est_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      start_r <= start_nxt;
      heating_r <= heating_nxt;
    end
  end

  // protection
  always_comb
  begin
    trip_nxt = run && (trip_r || (!overload_protection_mode_r[1] &&
               resistor_temperature_estimate_r >= EST_FULL));
    if (inhibit_r)
      inhibit_nxt = run && overload_protection_mode_r[1] &&
                    resistor_temperature_estimate_r >= EST_RELEASE;
    else
      inhibit_nxt = run && overload_protection_mode_r[1] &&
                    resistor_temperature_estimate_r >= EST_FULL;
    events = '0;
    events[ST_WARN_BIT] = brake_heat_warning && !warn_q;
    events[ST_TRIP_BIT] = trip_nxt && !trip_r;
    events[ST_INH_BIT] = inhibit_nxt && !inhibit_r;
    events[ST_CFG_BIT] = enable_r && !cfg_ok;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      trip_r <= 1'b0;
      inhibit_r <= 1'b0;
      warn_q <= 1'b0;
    end
    else
    begin
      trip_r <= trip_nxt;
      inhibit_r <= inhibit_nxt;
      warn_q <= brake_heat_warning;
    end
  end

  assign brake_gate_en = brake_request && !inhibit_r;
  assign brake_heat_warning = brake_gate_en &&
    resistor_temperature_estimate_r > EST_WARN;
  assign resistor_overtemp_trip = trip_r;
  assign irq = |(status_r & mask_r);
endmodule

/* File: src/brtg_pkg.sv */
// constants for the brake resistor thermal guard
package brtg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POWER = 8'h04;
  localparam logic [7:0] OFF_TAU = 8'h08;
  localparam logic [7:0] OFF_RES = 8'h0C;
  localparam logic [7:0] OFF_EST = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // status bits
  localparam int ST_WARN_BIT = 0;
  localparam int ST_TRIP_BIT = 1;
  localparam int ST_INH_BIT = 2;
  localparam int ST_CFG_BIT = 3;
  localparam int ST_W = 4;
  // estimate: 2^24 is full temperature
  localparam int EST_W = 25;
  localparam int EST_FRAC = 24;
  localparam logic [EST_W-1:0] EST_FULL = 25'h1000000;
  localparam logic [EST_W-1:0] EST_WARN = 25'h0C00000;
  localparam logic [EST_W-1:0] EST_RELEASE = 25'h0F33333;
  // resistance is held in 0.1 ohm units
  localparam logic [63:0] RES_SCALE = 64'hA;
  // model step of 1 ms at a 10 ns clock; thermal constant in ms
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 64;
  typedef enum logic [2:0] {
    BRTG_IDLE = 3'b000,
    BRTG_POW = 3'b001,
    BRTG_FRAC = 3'b011,
    BRTG_TAU = 3'b010,
    BRTG_APPLY = 3'b110
  } brtg_state_e;
endpackage

/* File: src/brtg_div_if.sv */
// request and answer wires between the model and its divider
interface brtg_div_if #(
  parameter int W = 64
);
  logic start;
  logic [W-1:0] num;
  logic [W-1:0] den;
  logic done;
  logic [W-1:0] quot;
  modport requester (output start, output num, output den,
                     input done, input quot);
  modport divider (input start, input num, input den,
                   output done, output quot);
endinterface

/* File: src/brtg_divider.sv */
// serial restoring divider, one quotient bit per clock
module brtg_divider #(
  parameter int W = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  brtg_div_if.divider div
);
  if (W < 8 || W > 128)
    $error("brtg_divider: W out of range");

  logic [W:0] rem_r, rem_nxt;
  logic [W-1:0] quo_r, quo_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic [W:0] trial;

  always_comb
  begin
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    trial = {rem_r[W-1:0], quo_r[W-1]};
    if (div.start)
    begin
      rem_nxt = '0;
      quo_nxt = div.num;
      cnt_nxt = 8'(W);
    end
    else if (cnt_r != 8'h00)
    begin
      // den of zero yields all ones
      if (trial >= {1'b0, div.den})
      begin
        rem_nxt = trial - {1'b0, div.den};
        quo_nxt = {quo_r[W-2:0], 1'b1};
      end
      else
      begin
        rem_nxt = trial;
        quo_nxt = {quo_r[W-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - 8'h01;
      done_nxt = (cnt_r == 8'h01);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rem_r <= '0;
      quo_r <= '0;
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign div.done = done_r;
  assign div.quot = quo_r;
endmodule

/* File: verification/brtg_drive_model.sv */
// gate control request and trip handler at the far side of the guard
module brtg_drive_model #(
  parameter logic [15:0] VOLTS = 16'h0064
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic brake_cmd,
  input wire logic resistor_overtemp_trip,
  output logic brake_request,
  output logic [15:0] dc_bus_voltage
);
  timeunit 1ns;
  timeprecision 1ns;
  assign dc_bus_voltage = VOLTS;
  initial brake_request = 1'b0;
  // a tripped drive stops braking
  always @(posedge core_clk)
  begin
    brake_request <= !rst && brake_cmd && !resistor_overtemp_trip;
  end
endmodule

/* File: verification/brtg_guard_chk.sv */
// port assertions for the thermal guard
module brtg_guard_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic brake_request,
  input wire logic brake_gate_en,
  input wire logic brake_heat_warning,
  input wire logic resistor_overtemp_trip,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_gate_needs_req: assert property (brake_gate_en |-> brake_request)
    else $error("gate on without request");
  a_warn_needs_gate: assert property (
    brake_heat_warning |-> brake_gate_en)
    else $error("warning while switch off");
  a_one_wait: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access not one wait cycle");
  a_idle_no_wait: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_rdata_holds: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_inhibit_holds: assert property (
    $fell(brake_gate_en) && brake_request && $past(brake_request)
    |-> !brake_gate_en [*8])
    else $error("inhibit released too soon");
  a_trip_latched: assert property (
    resistor_overtemp_trip && !avs_write && !$past(avs_write)
    |=> resistor_overtemp_trip)
    else $error("trip dropped without write");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !resistor_overtemp_trip && !irq && avs_readdata == 32'h0)
    else $error("outputs active in reset");
  c_trip: cover property ($rose(resistor_overtemp_trip));
  c_inhibit: cover property ($fell(brake_gate_en) && brake_request);
  c_warn: cover property ($rose(brake_heat_warning));
endmodule
bind brtg_guard brtg_guard_chk i_brtg_guard_chk (
  .core_clk(core_clk),
  .rst(rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .brake_request(brake_request),
  .brake_gate_en(brake_gate_en),
  .brake_heat_warning(brake_heat_warning),
  .resistor_overtemp_trip(resistor_overtemp_trip),
  .irq(irq)
);

/* File: verification/tb_brtg_guard.sv */
// register-driven testbench for the thermal guard
module tb_brtg_guard
  import brtg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 200;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic brake_cmd = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic brake_request;
  logic brake_gate_en;
  logic brake_heat_warning;
  logic resistor_overtemp_trip;
  logic irq;
  logic [15:0] dc_bus_voltage;
  logic [31:0] v;
  logic [31:0] p;
  int k;
  int n_errors = 0;
  int comparisons = 0;
  // estimate after each cooling step at tau 40
  logic [31:0] cool_est [3] = '{32'hF9999A, 32'hF35C2A, 32'hED46A9};

  brtg_guard #(.TICK_CYC(TICK)) i_brtg_guard (
    .core_clk(core_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .brake_request(brake_request),
    .dc_bus_voltage(dc_bus_voltage),
    .brake_gate_en(brake_gate_en),
    .brake_heat_warning(brake_heat_warning),
    .resistor_overtemp_trip(resistor_overtemp_trip),
    .irq(irq)
  );
  brtg_drive_model #(.VOLTS(16'h0064)) i_brtg_drive_model (
    .core_clk(core_clk),
    .rst(rst),
    .brake_cmd(brake_cmd),
    .resistor_overtemp_trip(resistor_overtemp_trip),
    .brake_request(brake_request),
    .dc_bus_voltage(dc_bus_voltage)
  );

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // one Avalon access, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
             input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, v & m, e);
  endtask

  // wait for trip or for the switch held off against a request
  task wait_hot;
    k = 0;
    while (!(resistor_overtemp_trip === 1'b1 || (brake_request === 1'b1
           && brake_gate_en === 1'b0)) && k < 2000)
    begin
      @(posedge core_clk);
      k++;
    end
    chk("hot_wait", 32'(k < 2000), 32'h1);
  endtask

  task heat(input logic [1:0] m);
    bus(1'b1, OFF_CTRL, {26'h0, m, 4'h1});
    brake_cmd <= 1'b1;
    wait_hot();
    chk("inhibit", 32'(brake_request & !brake_gate_en), 32'(m > 1));
    rdchk(OFF_EST, 32'h1FFFFFF, 32'(EST_FULL), "est_full");
    chk("trip", 32'(resistor_overtemp_trip), 32'(m < 2));
    if (m == 2'h0)
    begin
      rdchk(OFF_STATUS, 32'h2, 32'h2, "trip_status");
      chk("irq_masked", 32'(irq), 32'h0);
      bus(1'b1, OFF_MASK, 32'h2);
      chk("irq_on", 32'(irq), 32'h1);
      rdchk(OFF_MASK, 32'hFFFFFFFF, 32'h2, "mask_back");
      bus(1'b1, OFF_STATUS, 32'h2);
      chk("irq_cleared", 32'(irq), 32'h0);
    end
    brake_cmd <= 1'b0;
    bus(1'b1, OFF_CTRL, {26'h0, m, 4'h0});
    repeat (5) @(posedge core_clk);
    chk("trip_off", 32'(resistor_overtemp_trip), 32'h0);
    rdchk(OFF_EST, 32'h1FFFFFF, 32'h0, "est_off");
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk(OFF_CTRL, 32'h30, 32'h0, "mode_reset");
    rdchk(OFF_EST, 32'h1FFFFFF, 32'h0, "est_reset");
    rdchk(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
    // enabled with no configuration: model must stay idle
    bus(1'b1, OFF_CTRL, 32'h1);
    brake_cmd <= 1'b1;
    repeat (3 * TICK) @(posedge core_clk);
    rdchk(OFF_STATUS, 32'h8, 32'h8, "cfg_missing");
    rdchk(OFF_EST, 32'h1FFFFFF, 32'h0, "est_unconfigured");
    brake_cmd <= 1'b0;
    bus(1'b1, OFF_POWER, 32'h64);
    bus(1'b1, OFF_TAU, 32'h1);
    bus(1'b1, OFF_RES, 32'h64);
    rdchk(OFF_POWER, 32'hFFFFFFFF, 32'h64, "power_back");
    rdchk(OFF_TAU, 32'hFFFFFFFF, 32'h1, "tau_back");
    rdchk(OFF_RES, 32'hFFFFFFFF, 32'h64, "res_back");
    bus(1'b1, OFF_STATUS, 32'hF);
    rdchk(OFF_STATUS, 32'h8, 32'h0, "cfg_loaded");
    for (int m = 0; m < 4; m++)
      heat(2'(m));
    // inhibit until the estimate cools below 95 %
    bus(1'b1, OFF_TAU, 32'h28);
    bus(1'b1, OFF_STATUS, 32'hF);
    bus(1'b1, OFF_CTRL, 32'h21);
    brake_cmd <= 1'b1;
    wait_hot();
    rdchk(OFF_STATUS, 32'h6, 32'h4, "inhibit_status");
    rdchk(OFF_EST, 32'h1FFFFFF, 32'(EST_FULL), "est_at_full");
    p = v;
    for (int i = 0; i < 3; i++)
    begin
      k = 0;
      while (v === p && k < 200)
      begin
        bus(1'b0, OFF_EST, 32'h0);
        k++;
      end
      chk("cool_wait", 32'(k < 200), 32'h1);
      chk("est_cooling", v, cool_est[i]);
      chk("gate_cooling", 32'(brake_gate_en), 32'(i == 2));
      chk("warning", 32'(brake_heat_warning), 32'(i == 2));
      p = v;
    end
    brake_cmd <= 1'b0;
    give_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
